// File: inc/dual_timer_pkg.sv
package dual_timer_pkg;

  // Register offsets on the special-function register port.
  localparam logic [7:0] OFS_CTRL_A = 8'hB2;
  localparam logic [7:0] OFS_DATA_A = 8'hB3;
  localparam logic [7:0] OFS_CTRL_B = 8'hB4;
  localparam logic [7:0] OFS_CMP_B = 8'hB5;
  localparam logic [7:0] OFS_DATA_B = 8'hB6;
  localparam logic [7:0] OFS_PWM_HI = 8'hB7;

  // Values after reset.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CMP = 8'hFF;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [3:0] RST_PWM_HI = 4'h0;
  localparam logic [9:0] RST_PWM_CNT = 10'h000;

  // Field positions of timer_a_control.
  localparam int BIT_EN_A = 7;
  localparam int BIT_PE_A = 6;
  localparam int BIT_CAP_A = 5;
  localparam int BIT_CKS_A_HI = 4;
  localparam int BIT_CKS_A_LO = 2;
  localparam int BIT_CONT = 1;
  localparam int BIT_RUN = 0;

  // Field positions of timer_b_control.
  localparam int BIT_POL = 7;
  localparam int BIT_WIDE = 6;
  localparam int BIT_PWM_EN = 5;
  localparam int BIT_CAP_B = 4;
  localparam int BIT_CKS_B_HI = 3;
  localparam int BIT_CKS_B_LO = 2;

  // Field positions of pwm_high_bits.
  localparam int BIT_PE_B = 7;
  localparam int BIT_PER_HI = 3;
  localparam int BIT_PER_LO = 2;
  localparam int BIT_DUTY_HI = 1;
  localparam int BIT_DUTY_LO = 0;

  // Clock source codes.
  localparam logic [2:0] CKS_A_DIV2 = 3'h0;
  localparam logic [2:0] CKS_A_DIV4 = 3'h1;
  localparam logic [2:0] CKS_A_DIV16 = 3'h2;
  localparam logic [2:0] CKS_A_DIV64 = 3'h3;
  localparam logic [2:0] CKS_A_DIV256 = 3'h4;
  localparam logic [2:0] CKS_A_DIV1024 = 3'h5;
  localparam logic [2:0] CKS_A_DIV4096 = 3'h6;
  localparam logic [2:0] CKS_A_EXT = 3'h7;
  localparam logic [1:0] CKS_B_DIV1 = 2'h0;
  localparam logic [1:0] CKS_B_DIV2 = 2'h1;
  localparam logic [1:0] CKS_B_DIV16 = 2'h2;
  localparam logic [1:0] CKS_B_CHAIN = 2'h3;

  // Prescaler taps: tap k pulses once every 2^(k+1) system clocks.
  localparam int PRESCALE_W = 12;
  localparam int TAP_DIV2 = 0;
  localparam int TAP_DIV4 = 1;
  localparam int TAP_DIV16 = 3;
  localparam int TAP_DIV64 = 5;
  localparam int TAP_DIV256 = 7;
  localparam int TAP_DIV1024 = 9;
  localparam int TAP_DIV4096 = 11;

  localparam int PWM_W = 10;
  localparam logic [9:0] PWM_ONE = 10'h001;
  localparam int TRIG_LINES = 3;
  localparam int LINE_EXT = 0;
  localparam int LINE_CAP_A = 1;
  localparam int LINE_CAP_B = 2;

endpackage : dual_timer_pkg

// File: rtl/clk_prescaler.sv
`timescale 1ns/1ps
module clk_prescaler
  import dual_timer_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  output logic [PRESCALE_W-1:0] tick_o
);

  logic [PRESCALE_W-1:0] div_q;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 12'h001;
    end
  end

  // Each tap is a one-cycle count enable, high where its low bits are all ones.
  for (genvar k = 0; k < PRESCALE_W; k++) begin : g_tap
    assign tick_o[k] = &div_q[k:0];
  end

endmodule : clk_prescaler

// File: rtl/edge_sync.sv
`timescale 1ns/1ps
module edge_sync
  import dual_timer_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [TRIG_LINES-1:0] pin_i,
  output logic [TRIG_LINES-1:0] rise_o
);

  logic [TRIG_LINES-1:0] meta_q;
  logic [TRIG_LINES-1:0] sync_q;
  logic [TRIG_LINES-1:0] last_q;

  // Two flops per line before the edge detector; only sync_q reads meta_q.
  for (genvar k = 0; k < TRIG_LINES; k++) begin : g_line
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        meta_q[k] <= 1'b0;
        sync_q[k] <= 1'b0;
        last_q[k] <= 1'b0;
      end else begin
        meta_q[k] <= pin_i[k];
        sync_q[k] <= meta_q[k];
        last_q[k] <= sync_q[k];
      end
    end
    assign rise_o[k] = sync_q[k] & ~last_q[k];
  end

endmodule : edge_sync

// File: rtl/dual_timer_capture_pwm.sv
// How it works
// - Two 8-bit counters run alone or chain into one 16-bit counter.
// - Timer A clock: system clock over 2..4096, or the external count pin.
// - Timer B clock: system clock over 1, 2, 16, or timer A's clock.
// - External source counts rising edges of the count pin, pin is input.
// - In 8-bit mode each timer interrupts when count equals its compare.
// - 16-bit counter wraps to zero at compare match; only timer A interrupts.
// - In capture mode a trigger edge copies the count into the capture register.
// - After a capture the counter clears to zero and keeps counting.
// - Compare match interrupts still occur in capture mode.
// - A capture-select bit of 1 puts that timer into capture mode.
// - Shared address reads capture register in capture mode, else live count; timer B reads duty in PWM mode.
// - 16-bit capture copies and clears the combined counter.
// - Timer A pin shows its compare toggle; timer B pin shows compare or PWM.
// - PWM mode drives a waveform of up to 10 bits on timer B's pin.
// - PWM period and duty are two high bits above their 8-bit registers.
// - Duty equal to period holds output at polarity; zero duty holds its inverse.
// - Compare output mode toggles the pin at each match, a square wave.
// - Polarity 0 sets the output at duty match, 1 clears it.
// - Writing run as 1 clears the counter and starts; 0 stops it.
// - Clearing continue holds the count; setting it resumes counting.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module dual_timer_capture_pwm
  import dual_timer_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ext_count_in_i,
  input wire logic capture_trig_a_i,
  input wire logic capture_trig_b_i,
  output logic ext_count_input_o,
  output logic timer_a_pin_o,
  output logic timer_a_pin_oe_o,
  output logic timer_b_pin_o,
  output logic timer_b_pin_oe_o,
  output logic irq_a_o,
  output logic irq_b_o
);

  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] cmp_a_q;
  logic [7:0] cmp_b_q;
  logic [7:0] period_lo_q;
  logic [7:0] duty_lo_q;
  logic [3:0] pwm_hi_q;
  logic pe_b_q;
  logic [7:0] cnt_a_q;
  logic [7:0] cnt_b_q;
  logic [7:0] cap_a_q;
  logic [7:0] cap_b_q;
  logic [PWM_W-1:0] pwm_cnt_q;
  logic pwm_out_q;
  logic tog_a_q;
  logic tog_b_q;
  logic irq_a_q;
  logic irq_b_q;
  logic [7:0] rdata_q;

  logic [PRESCALE_W-1:0] div_tick;
  logic [TRIG_LINES-1:0] trig_rise;
  logic tick_a;
  logic tick_b;

  clk_prescaler u_prescaler (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .tick_o(div_tick)
  );

  edge_sync u_edge_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .pin_i({capture_trig_b_i, capture_trig_a_i, ext_count_in_i}),
    .rise_o(trig_rise)
  );

  // Control fields.
  logic en_a;
  logic pe_a;
  logic cap_sel_a;
  logic [2:0] clk_sel_a;
  logic cont_a;
  logic run_a;
  logic pwm_polarity;
  logic wide;
  logic pwm_en;
  logic cap_sel_b;
  logic [1:0] clk_sel_b;
  logic cont_b;
  logic run_b;

  assign en_a = ctrl_a_q[BIT_EN_A];
  assign pe_a = ctrl_a_q[BIT_PE_A];
  assign cap_sel_a = ctrl_a_q[BIT_CAP_A];
  assign clk_sel_a = ctrl_a_q[BIT_CKS_A_HI:BIT_CKS_A_LO];
  assign cont_a = ctrl_a_q[BIT_CONT];
  assign run_a = ctrl_a_q[BIT_RUN];
  assign pwm_polarity = ctrl_b_q[BIT_POL];
  assign wide = ctrl_b_q[BIT_WIDE];
  assign pwm_en = ctrl_b_q[BIT_PWM_EN];
  assign cap_sel_b = ctrl_b_q[BIT_CAP_B];
  assign clk_sel_b = ctrl_b_q[BIT_CKS_B_HI:BIT_CKS_B_LO];
  assign cont_b = ctrl_b_q[BIT_CONT];
  assign run_b = ctrl_b_q[BIT_RUN];

  // Address decode.
  logic wr_ctrl_a;
  logic wr_data_a;
  logic wr_ctrl_b;
  logic wr_cmp_b;
  logic wr_data_b;
  logic wr_pwm_hi;

  assign wr_ctrl_a = reg_wr_i && (reg_addr_i == OFS_CTRL_A);
  assign wr_data_a = reg_wr_i && (reg_addr_i == OFS_DATA_A);
  assign wr_ctrl_b = reg_wr_i && (reg_addr_i == OFS_CTRL_B);
  assign wr_cmp_b = reg_wr_i && (reg_addr_i == OFS_CMP_B);
  assign wr_data_b = reg_wr_i && (reg_addr_i == OFS_DATA_B);
  assign wr_pwm_hi = reg_wr_i && (reg_addr_i == OFS_PWM_HI);

  always_comb begin
    unique case (clk_sel_a)
      CKS_A_DIV2: tick_a = div_tick[TAP_DIV2];
      CKS_A_DIV4: tick_a = div_tick[TAP_DIV4];
      CKS_A_DIV16: tick_a = div_tick[TAP_DIV16];
      CKS_A_DIV64: tick_a = div_tick[TAP_DIV64];
      CKS_A_DIV256: tick_a = div_tick[TAP_DIV256];
      CKS_A_DIV1024: tick_a = div_tick[TAP_DIV1024];
      CKS_A_DIV4096: tick_a = div_tick[TAP_DIV4096];
      CKS_A_EXT: tick_a = trig_rise[LINE_EXT];
    endcase
  end

  // Timer B can only reach the count pin through timer A's selection.
  always_comb begin
    unique case (clk_sel_b)
      CKS_B_DIV1: tick_b = 1'b1;
      CKS_B_DIV2: tick_b = div_tick[TAP_DIV2];
      CKS_B_DIV16: tick_b = div_tick[TAP_DIV16];
      CKS_B_CHAIN: tick_b = tick_a;
    endcase
  end

  assign ext_count_input_o = (clk_sel_a == CKS_A_EXT);

  // Count enables, matches, captures and clears.
  logic cnt_en_a;
  logic cnt_en_b;
  logic match_a;
  logic hit_a;
  logic hit_b;
  logic cap_ev_a;
  logic cap_ev_b;
  logic clr_a;
  logic clr_b;

  assign cnt_en_a = en_a && run_a && cont_a && tick_a;
  assign cnt_en_b = run_b && cont_b && tick_b && !pwm_en && !wide;
  assign match_a = wide ? ({cnt_b_q, cnt_a_q} == {cmp_b_q, cmp_a_q}) : (cnt_a_q == cmp_a_q);
  assign hit_a = cnt_en_a && match_a;
  assign hit_b = cnt_en_b && (cnt_b_q == cmp_b_q);
  assign cap_ev_a = cap_sel_a && trig_rise[LINE_CAP_A];
  assign cap_ev_b = cap_sel_b && !wide && trig_rise[LINE_CAP_B];
  assign clr_a = (wr_ctrl_a && reg_wdata_i[BIT_RUN]) || cap_ev_a;
  assign clr_b = wide ? clr_a : ((wr_ctrl_b && reg_wdata_i[BIT_RUN]) || cap_ev_b);

  // Control and data registers written by software.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_a_q <= RST_CTRL;
      ctrl_b_q <= RST_CTRL;
      cmp_a_q <= RST_CMP;
      cmp_b_q <= RST_CMP;
      period_lo_q <= RST_PERIOD;
      duty_lo_q <= RST_ZERO;
      pwm_hi_q <= RST_PWM_HI;
      pe_b_q <= 1'b0;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_q <= reg_wdata_i;
      end
      if (wr_ctrl_b) begin
        ctrl_b_q <= reg_wdata_i;
      end
      if (wr_data_a) begin
        cmp_a_q <= reg_wdata_i;
      end
      // The shared offset holds the period in PWM mode and the compare value otherwise.
      if (wr_cmp_b && pwm_en) begin
        period_lo_q <= reg_wdata_i;
      end
      if (wr_cmp_b && !pwm_en) begin
        cmp_b_q <= reg_wdata_i;
      end
      if (wr_data_b && pwm_en) begin
        duty_lo_q <= reg_wdata_i;
      end
      if (wr_pwm_hi) begin
        pe_b_q <= reg_wdata_i[BIT_PE_B];
        pwm_hi_q <= reg_wdata_i[BIT_PER_HI:BIT_DUTY_LO];
      end
    end
  end

  // Timer A counter, also the low byte of the chained counter.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_a_q <= RST_ZERO;
    end else if (clr_a || hit_a) begin
      cnt_a_q <= RST_ZERO;
    end else if (cnt_en_a) begin
      cnt_a_q <= cnt_a_q + 8'h01;
    end
  end

  // Timer B counter, the high byte while chained.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_b_q <= RST_ZERO;
    end else if (clr_b) begin
      cnt_b_q <= RST_ZERO;
    end else if (wide) begin
      if (hit_a) begin
        cnt_b_q <= RST_ZERO;
      end else if (cnt_en_a && (&cnt_a_q)) begin
        cnt_b_q <= cnt_b_q + 8'h01;
      end
    end else if (hit_b) begin
      cnt_b_q <= RST_ZERO;
    end else if (cnt_en_b) begin
      cnt_b_q <= cnt_b_q + 8'h01;
    end
  end

  // Capture registers.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_a_q <= RST_ZERO;
      cap_b_q <= RST_ZERO;
    end else begin
      if (cap_ev_a) begin
        cap_a_q <= cnt_a_q;
      end
      if ((cap_ev_a && wide) || cap_ev_b) begin
        cap_b_q <= cnt_b_q;
      end
    end
  end

  // Compare toggles and interrupt pulses.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tog_a_q <= 1'b0;
      tog_b_q <= 1'b0;
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
    end else begin
      tog_a_q <= tog_a_q ^ hit_a;
      tog_b_q <= tog_b_q ^ hit_b;
      irq_a_q <= hit_a;
      irq_b_q <= hit_b;
    end
  end

  // PWM generator on timer B's clock.
  logic [PWM_W-1:0] pwm_period;
  logic [PWM_W-1:0] pwm_duty;
  logic pwm_tick;
  logic pwm_active;

  assign pwm_period = {pwm_hi_q[BIT_PER_HI:BIT_PER_LO], period_lo_q};
  assign pwm_duty = {pwm_hi_q[BIT_DUTY_HI:BIT_DUTY_LO], duty_lo_q};
  assign pwm_tick = pwm_en && run_b && cont_b && tick_b;
  // Duty equal to period counts as always active so the output stays flat.
  assign pwm_active = (pwm_cnt_q < pwm_duty) || (pwm_duty == pwm_period);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwm_cnt_q <= RST_PWM_CNT;
    end else if (!pwm_en || (wr_ctrl_b && reg_wdata_i[BIT_RUN])) begin
      pwm_cnt_q <= RST_PWM_CNT;
    end else if (pwm_tick) begin
      if (pwm_cnt_q >= pwm_period - PWM_ONE) begin
        pwm_cnt_q <= RST_PWM_CNT;
      end else begin
        pwm_cnt_q <= pwm_cnt_q + PWM_ONE;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwm_out_q <= 1'b0;
    end else begin
      pwm_out_q <= pwm_active ~^ pwm_polarity;
    end
  end

  // Register read port: data stand in the cycle after the strobe only.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= RST_ZERO;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_CTRL_A: rdata_q <= ctrl_a_q;
        OFS_DATA_A: rdata_q <= cap_sel_a ? cap_a_q : cnt_a_q;
        OFS_CTRL_B: rdata_q <= ctrl_b_q;
        OFS_DATA_B: rdata_q <= cap_sel_b ? cap_b_q : (pwm_en ? duty_lo_q : cnt_b_q);
        default: rdata_q <= RST_ZERO;
      endcase
    end else begin
      rdata_q <= RST_ZERO;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_a_o = irq_a_q;
  assign irq_b_o = irq_b_q;
  assign timer_a_pin_o = tog_a_q;
  assign timer_a_pin_oe_o = pe_a;
  assign timer_b_pin_o = pwm_en ? pwm_out_q : (wide ? tog_a_q : tog_b_q);
  assign timer_b_pin_oe_o = pe_b_q;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_EXT_ONLY_ON_EDGE: assert property ((clk_sel_a == CKS_A_EXT) && !trig_rise[LINE_EXT] |-> !tick_a)
    else $error("timer A ticked without a count pin edge");

  AST_B_FAST_TICK: assert property ((clk_sel_b == CKS_B_DIV1) |-> tick_b)
    else $error("timer B divide-by-one source missed a cycle");

  AST_MATCH_IRQ_A: assert property (en_a && run_a && cont_a && tick_a && !wide && (cnt_a_q == cmp_a_q)
    |=> irq_a_q ##1 !irq_a_q)
    else $error("timer A match did not give a one-cycle interrupt");

  AST_WIDE_WRAP: assert property (wide && cnt_en_a && ({cnt_b_q, cnt_a_q} == {cmp_b_q, cmp_a_q})
    |=> (cnt_a_q == 8'h00) && (cnt_b_q == 8'h00) && irq_a_q && !irq_b_q)
    else $error("chained counter did not wrap to zero with timer A interrupt");

  AST_NO_IRQ_B_WIDE: assert property (irq_b_q |-> !$past(wide))
    else $error("timer B interrupt raised while chained");

  AST_CAPTURE_LOAD: assert property (cap_ev_a |=> (cap_a_q == $past(cnt_a_q)) && (cnt_a_q == 8'h00))
    else $error("capture did not load timer A count and clear it");

  AST_CAPTURE_WIDE: assert property (cap_ev_a && wide |=> (cap_b_q == $past(cnt_b_q)) && (cnt_b_q == 8'h00))
    else $error("wide capture did not load and clear the high byte");

  AST_READ_CAPTURE: assert property (reg_rd_i && (reg_addr_i == OFS_DATA_A) && cap_sel_a
    |=> reg_rdata_o == $past(cap_a_q))
    else $error("shared address did not return the capture value");

  AST_RUN_CLEARS: assert property (wr_ctrl_a && reg_wdata_i[BIT_RUN] |=> cnt_a_q == 8'h00)
    else $error("run write did not clear timer A");

  AST_PAUSE_HOLDS: assert property (!cont_a && !clr_a && !wide |=> $stable(cnt_a_q))
    else $error("timer A moved while paused");

  AST_TOGGLE: assert property (hit_b |=> tog_b_q != $past(tog_b_q))
    else $error("timer B compare output did not toggle on match");

  AST_PWM_FLAT_HIGH: assert property (pwm_en && pwm_polarity && (pwm_duty == pwm_period) [*2] |-> pwm_out_q)
    else $error("full duty with positive polarity did not hold high");

  AST_PWM_FLAT_ZERO: assert property (pwm_en && !pwm_polarity && (pwm_duty == 10'h000) && (pwm_period != 10'h000) [*2]
    |-> pwm_out_q)
    else $error("zero duty with negative polarity did not hold high");

endmodule : dual_timer_capture_pwm

// File: verification/timer_pin_model.sv
`timescale 1ns/1ps
module timer_pin_model
  import dual_timer_pkg::*;
(
  input wire logic core_clk_i,
  output logic ext_count_in_o,
  output logic capture_trig_a_o,
  output logic capture_trig_b_o
);
  logic [TRIG_LINES-1:0] lines_q;

  assign ext_count_in_o = lines_q[LINE_EXT];
  assign capture_trig_a_o = lines_q[LINE_CAP_A];
  assign capture_trig_b_o = lines_q[LINE_CAP_B];

  initial begin
    lines_q = 3'h0;
  end

  // Each level is held four clocks so the two-flop synchroniser sees every rising edge.
  task automatic pulse(input int line, input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      lines_q[line] <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      lines_q[line] <= 1'b0;
      repeat (3) @(posedge core_clk_i);
    end
  endtask : pulse
endmodule : timer_pin_model

// File: verification/dual_timer_capture_pwm_bench.sv
`timescale 1ns/1ps
module dual_timer_capture_pwm_bench;
  import dual_timer_pkg::*;
  logic core_clk_i;
  logic resetn_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  wire logic [7:0] reg_rdata_o;
  wire logic ext_count_in, trig_a, trig_b, ext_dir, pin_a, oe_a, pin_b, oe_b, irq_a, irq_b;
  wire logic [3:0] mon = {pin_b, pin_a, irq_b, irq_a};
  int failures, n_compared, cyc, irq_b_seen, g, nb;
  int divs[7] = '{2, 4, 16, 64, 256, 1024, 4096};
  int bdiv[4] = '{1, 2, 16, 2};

  dual_timer_capture_pwm dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ext_count_in_i(ext_count_in),
    .capture_trig_a_i(trig_a), .capture_trig_b_i(trig_b), .ext_count_input_o(ext_dir),
    .timer_a_pin_o(pin_a), .timer_a_pin_oe_o(oe_a), .timer_b_pin_o(pin_b), .timer_b_pin_oe_o(oe_b),
    .irq_a_o(irq_a), .irq_b_o(irq_b)
  );

  timer_pin_model u_pins (
    .core_clk_i(core_clk_i), .ext_count_in_o(ext_count_in), .capture_trig_a_o(trig_a),
    .capture_trig_b_o(trig_b)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // The slowest prescaler sweep dominates the run; the ceiling leaves ample margin over it.
  always @(posedge core_clk_i) begin
    cyc++;
    if (irq_b === 1'b1) irq_b_seen++;
    if (cyc == 80000) begin
      failures++;
      close_out();
    end
  end

  task close_out;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task done(input string name);
    $display("test %s done", name);
  endtask : done

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, e);
  endtask : rd

  // Cycles between the first and second event on a watched output; an event is a high irq or a pin toggle.
  task gap(input int i, input bit tog, output int n);
    logic p, c, hit;
    p = mon[i];
    n = 0;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge core_clk_i);
        #1 c = mon[i];
        hit = tog ? (c !== p) : (c === 1'b1);
        p = c;
        n++;
      end while (!hit && n < 30000);
    end
  endtask : gap

  task highs(input int n, output int h);
    repeat (8) @(posedge core_clk_i);
    h = 0;
    repeat (n) begin
      @(posedge core_clk_i);
      #1 if (pin_b === 1'b1) h++;
    end
  endtask : highs

  initial begin
    resetn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    repeat (4) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    #1 check({ext_dir, pin_a, oe_a, pin_b, oe_b, irq_a, irq_b}, 0);
    for (int a = 8'hB0; a <= 8'hB7; a++) begin
      rd(a[7:0], 8'h00);
    end
    done("reset");
    wr(OFS_DATA_A, 8'h04);
    for (int k = 0; k < 7; k++) begin
      wr(OFS_CTRL_A, 8'hC3 | {3'h0, k[2:0], 2'h0});
      gap(0, 1'b0, g);
      check(g, divs[k] * 5);
    end
    wr(OFS_CTRL_A, 8'hC3);
    gap(2, 1'b1, g);
    check(g, 10);
    check(oe_a, 1'b1);
    done("timer_a");
    wr(OFS_CMP_B, 8'h04);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTRL_B, 8'h03 | {4'h0, k[1:0], 2'h0});
      gap(1, 1'b0, g);
      check(g, bdiv[k] * 5);
    end
    gap(3, 1'b1, g);
    check(g, 10);
    done("timer_b");
    wr(OFS_CMP_B, 8'h01);
    wr(OFS_CTRL_B, 8'h4F);
    wr(OFS_CTRL_A, 8'hC3);
    nb = irq_b_seen;
    gap(0, 1'b0, g);
    check(g, 522);
    wr(OFS_PWM_HI, 8'h80);
    gap(3, 1'b1, g);
    check(g, 522);
    check(irq_b_seen - nb, 0);
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_PWM_HI, 8'h00);
    done("wide");
    wr(OFS_DATA_A, 8'h40);
    wr(OFS_CTRL_A, 8'h9F);
    #1 check(ext_dir, 1'b1);
    u_pins.pulse(LINE_EXT, 3);
    rd(OFS_DATA_A, 8'h03);
    wr(OFS_CTRL_A, 8'h9C);
    u_pins.pulse(LINE_EXT, 2);
    rd(OFS_DATA_A, 8'h03);
    wr(OFS_CTRL_A, 8'h9D);
    u_pins.pulse(LINE_EXT, 2);
    rd(OFS_DATA_A, 8'h00);
    wr(OFS_CTRL_A, 8'h9F);
    u_pins.pulse(LINE_EXT, 1);
    rd(OFS_DATA_A, 8'h01);
    done("event_count");
    wr(OFS_CTRL_A, 8'hBF);
    u_pins.pulse(LINE_EXT, 5);
    u_pins.pulse(LINE_CAP_A, 1);
    rd(OFS_DATA_A, 8'h05);
    u_pins.pulse(LINE_EXT, 2);
    rd(OFS_DATA_A, 8'h05);
    wr(OFS_CTRL_A, 8'h9E);
    rd(OFS_DATA_A, 8'h02);
    done("capture");
    // Timer B counts count-pin edges through timer A's selection while timer A itself is stopped.
    wr(OFS_CMP_B, 8'h40);
    wr(OFS_CTRL_B, 8'h1F);
    u_pins.pulse(LINE_EXT, 3);
    u_pins.pulse(LINE_CAP_B, 1);
    rd(OFS_DATA_B, 8'h03);
    wr(OFS_CTRL_B, 8'h5F);
    wr(OFS_CTRL_A, 8'hBF);
    u_pins.pulse(LINE_EXT, 257);
    u_pins.pulse(LINE_CAP_A, 1);
    rd(OFS_DATA_A, 8'h01);
    rd(OFS_DATA_B, 8'h01);
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_DATA_A, 8'h04);
    wr(OFS_CTRL_A, 8'hE3);
    gap(0, 1'b0, g);
    check(g, 10);
    done("capture_wide");
    wr(OFS_CTRL_B, 8'hA3);
    wr(OFS_CMP_B, 8'h02);
    wr(OFS_PWM_HI, 8'h84);
    wr(OFS_DATA_B, 8'h80);
    rd(OFS_DATA_B, 8'h80);
    check(oe_b, 1'b1);
    highs(258, g);
    check(g, 128);
    wr(OFS_CTRL_B, 8'h23);
    highs(258, g);
    check(g, 130);
    wr(OFS_CTRL_B, 8'hA3);
    wr(OFS_DATA_B, 8'h02);
    wr(OFS_PWM_HI, 8'h85);
    highs(300, g);
    check(g, 300);
    wr(OFS_DATA_B, 8'h00);
    wr(OFS_PWM_HI, 8'h84);
    highs(300, g);
    check(g, 0);
    check(pin_b, 1'b0);
    wr(OFS_CTRL_B, 8'h23);
    highs(300, g);
    check(g, 300);
    done("pwm");
    close_out();
  end
endmodule : dual_timer_capture_pwm_bench
